// >>> hw/oamie_top.sv
// OAM endpoint injection check, level filter and CPU extraction decision
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module oamie_top
	import oamie_pkg::*;
(
	input  wire logic                  CLK,
	input  wire logic                  RST,
	input  wire logic [OAMIE_AW-1:0]   ADDR,
	input  wire logic [OAMIE_DW-1:0]   WR_DATA,
	input  wire logic                  WR,
	input  wire logic                  RD,
	output logic      [OAMIE_DW-1:0]   RD_DATA,
	input  wire logic                  IN_VALID,
	input  wire logic                  IN_RX,
	input  wire logic [1:0]            IN_ACT,
	input  wire logic [1:0]            IN_POINT,
	input  wire logic [1:0]            IN_PDU_TYPE,
	input  wire logic [OAMIE_LVW-1:0]  IN_LEVEL,
	input  wire logic [OAMIE_OPW-1:0]  IN_OPCODE,
	input  wire logic                  IN_LOOPED,
	input  wire logic                  IN_ERROR,
	output logic                       OUT_VALID,
	output logic      [1:0]            OUT_VERDICT,
	output logic      [OAMIE_OPW-1:0]  OUT_OPCODE,
	output logic                       OUT_MAC_SWAP,
	output logic                       OUT_EXTRACT,
	output logic                       OUT_EXTR_POINT,
	output logic      [OAMIE_QW-1:0]   OUT_QUEUE,
	output logic      [OAMIE_OPW-1:0]  OUT_EXTR_OPCODE,
	output logic                       OUT_EXTR_MODIFIED,
	output logic                       OUT_EXTR_RESPONSE,
	output logic                       OUT_LM_COUNT
);

	oamie_state_s cur;
	oamie_state_s nxt;

	logic                 is_msg;
	logic [OAMIE_OPW-1:0] rsp_op;
	logic                 is_synthetic_loss_meas;

	oamie_opmap u_opmap (
		.op       (IN_OPCODE),
		.is_msg   (is_msg),
		.rsp_op   (rsp_op),
		.is_synthetic_loss_meas (is_synthetic_loss_meas)
	);

	logic                 ena;
	logic                 mpls;
	logic                 up;
	logic                 outer;
	logic [OAMIE_LVW-1:0] lvl;
	logic                 indep;
	logic                 synthetic_loss_meas;
	logic                 oam;
	logic                 inj_ok;
	logic [1:0]           exp_point;
	logic [1:0]           exp_act;
	logic [1:0]           verdict;
	logic                 proc;
	logic                 loopmsg;
	logic                 err_hit;
	logic                 type_hit;
	logic                 err_take;
	logic                 type_take;
	logic [2:0]           tmask;
	logic [OAMIE_ST_W-1:0] clr;
	logic [OAMIE_ST_W-1:0] set;
	logic                 lm_inc;

	always_comb begin
		nxt = cur;
		ena = cur.cfg[OAMIE_CFG_ENA];
		mpls = cur.cfg[OAMIE_CFG_MPLS];
		up = cur.cfg[OAMIE_CFG_UP];
		outer = cur.cfg[OAMIE_CFG_OUTER];
		lvl = cur.cfg[OAMIE_CFG_LVL_HI:OAMIE_CFG_LVL_LO];
		indep = cur.cfg[OAMIE_CFG_INDEP];
		synthetic_loss_meas = cur.cfg[OAMIE_CFG_SYNTHETIC_LOSS_MEAS];
		tmask = cur.extr[OAMIE_EXTR_TYPE_HI:OAMIE_EXTR_TYPE_LO];
		clr = '0;
		set = '0;

		// Expected injection command and point of this endpoint
		if (up) begin
			exp_act = masquerade_inject_cmd;
			exp_point = outer ? outer_analyzer_point : inner_analyzer_point;
		end else begin
			exp_act = plain_inject_cmd;
			exp_point = outer ? outer_rewriter_point : inner_rewriter_point;
		end
		inj_ok = (IN_ACT == exp_act) && (IN_POINT == exp_point);

		// Level independent lookups see every PDU as data
		oam = ena && (IN_PDU_TYPE != TYPE_NONE) && !indep;

		verdict = VERDICT_DATA;
		if (oam) begin
			if (mpls) begin
				if (IN_RX || inj_ok) begin
					verdict = VERDICT_PROCESS;
				end
			end else if (IN_LEVEL < lvl) begin
				verdict = VERDICT_DISCARD;
			end else if (IN_LEVEL > lvl) begin
				verdict = VERDICT_DATA;
			end else if (IN_RX || inj_ok) begin
				verdict = VERDICT_PROCESS;
			end else begin
				verdict = VERDICT_DATA;
			end
		end
		proc = (verdict == VERDICT_PROCESS);
		loopmsg = proc && IN_LOOPED && is_msg;

		// Extraction criteria, processed PDUs only
		err_hit = proc && IN_ERROR && cur.extr[OAMIE_EXTR_ERR_EN];
		type_hit = 1'b0;
		if (proc && IN_RX) begin
			unique case (IN_PDU_TYPE)
				type_y1731_pdu:         type_hit = tmask[0];
				type_mplstp_pdu:        type_hit = tmask[1];
				type_sequence_numbered: type_hit = tmask[2];
				TYPE_NONE:              type_hit = 1'b0;
			endcase
		end
		err_take = IN_VALID && err_hit
			&& !(cur.extr[OAMIE_EXTR_ERR_ONCE] && cur.done[OAMIE_ST_ERR]);
		type_take = IN_VALID && type_hit
			&& !(cur.extr[OAMIE_EXTR_TYPE_ONCE] && cur.done[OAMIE_ST_TYPE]);
		set[OAMIE_ST_ERR] = err_take && cur.extr[OAMIE_EXTR_ERR_ONCE];
		set[OAMIE_ST_TYPE] = type_take && cur.extr[OAMIE_EXTR_TYPE_ONCE];

		// Loss counting: Ethernet only, one flavor
		lm_inc = 1'b0;
		if (IN_VALID && ena && !mpls) begin
			if (synthetic_loss_meas) begin
				lm_inc = proc && is_synthetic_loss_meas;
			end else begin
				lm_inc = (verdict != VERDICT_DISCARD);
			end
		end

		// Decision output stage
		nxt.ov = IN_VALID;
		nxt.verdict = verdict;
		nxt.ext = err_take || type_take;
		nxt.q = cur.extr[OAMIE_EXTR_Q_HI:OAMIE_EXTR_Q_LO];
		nxt.op = loopmsg ? rsp_op : IN_OPCODE;
		nxt.swap = loopmsg;
		nxt.lmc = lm_inc;
		if (up && !IN_LOOPED) begin
			nxt.ept = EXTR_EGRESS;
		end else begin
			nxt.ept = EXTR_INGRESS;
		end
		nxt.eop = (up && loopmsg) ? rsp_op : IN_OPCODE;
		nxt.eresp = up && IN_LOOPED && proc;
		nxt.emod = IN_RX && !(err_take && !type_take && !IN_RX);

		// Register writes
		if (WR) begin
			unique case (ADDR)
				OAMIE_ADDR_CFG:    nxt.cfg = WR_DATA[OAMIE_CFG_W-1:0];
				OAMIE_ADDR_EXTR:   nxt.extr = WR_DATA[OAMIE_EXTR_W-1:0];
				OAMIE_ADDR_STATUS: clr = WR_DATA[OAMIE_ST_W-1:0];
				OAMIE_ADDR_LMCNT:  nxt.lm = '0;
				default:           nxt.cfg = cur.cfg;
			endcase
		end
		nxt.done = (cur.done & ~clr) | set;
		if (lm_inc) begin
			nxt.lm = (WR && ADDR == OAMIE_ADDR_LMCNT) ? 32'h00000001 : cur.lm + 32'h00000001;
		end

		// Read data for one cycle only
		nxt.rdata = '0;
		if (RD) begin
			unique case (ADDR)
				OAMIE_ADDR_CFG:    nxt.rdata = {{(OAMIE_DW-OAMIE_CFG_W){1'b0}}, cur.cfg};
				OAMIE_ADDR_EXTR:   nxt.rdata = {{(OAMIE_DW-OAMIE_EXTR_W){1'b0}}, cur.extr};
				OAMIE_ADDR_STATUS: nxt.rdata = {{(OAMIE_DW-OAMIE_ST_W){1'b0}}, cur.done};
				OAMIE_ADDR_LMCNT:  nxt.rdata = cur.lm;
				default:           nxt.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cur <= '0;
			cur.cfg <= OAMIE_CFG_RST;
			cur.extr <= OAMIE_EXTR_RST;
		end else begin
			cur <= nxt;
		end
	end

	assign RD_DATA = cur.rdata;
	assign OUT_VALID = cur.ov;
	assign OUT_VERDICT = cur.verdict;
	assign OUT_OPCODE = cur.op;
	assign OUT_MAC_SWAP = cur.swap;
	assign OUT_EXTRACT = cur.ext;
	assign OUT_EXTR_POINT = cur.ept;
	assign OUT_QUEUE = cur.q;
	assign OUT_EXTR_OPCODE = cur.eop;
	assign OUT_EXTR_MODIFIED = cur.emod;
	assign OUT_EXTR_RESPONSE = cur.eresp;
	assign OUT_LM_COUNT = cur.lmc;

endmodule
`default_nettype wire

// >>> include/oamie_pkg.sv
// Constants, types and register layout of the OAM PDU inject and extract block
// How it works
// - Tx PDU outside the active endpoint injection point goes through level filtering
// - Levels below the endpoint are discarded, above are passed as data
// - MPLS-TP endpoint processes every injected Tx PDU unless level independent
// - Endpoint takes the opcode from the PDU itself, not the injector
// - Only processed OAM PDUs are extracted, on errors or Rx PDU type
// - Each extraction criterion extracts once only or every match
// - Extraction goes only to an internal CPU queue
// - Tx extracts only on errors and unmodified; Rx extracts modified
// - MAC addresses are swapped only for looped message to response PDUs
// - Ingress extracts show analyzer changes, egress extracts rewriter changes
// - Down endpoint always extracts at the ingress point
// - Up endpoint extracts looped at ingress, non-looped at egress
// - LMM, DMM, LBM, SLM get response opcode at egress modification
// - Up looped extract is a copy of the outgoing response
// - Loss counting only for Ethernet endpoints, never MPLS
// - One loss flavor per endpoint, frame or synthetic, sharing counters
// - Level independent lookup processes every OAM PDU as data
package oamie_pkg;

	localparam int OAMIE_AW = 4;
	localparam int OAMIE_DW = 32;
	localparam int OAMIE_OPW = 8;
	localparam int OAMIE_QW = 3;
	localparam int OAMIE_LVW = 3;

	localparam logic [OAMIE_AW-1:0] OAMIE_ADDR_CFG    = 4'h0;
	localparam logic [OAMIE_AW-1:0] OAMIE_ADDR_EXTR   = 4'h4;
	localparam logic [OAMIE_AW-1:0] OAMIE_ADDR_STATUS = 4'h8;
	localparam logic [OAMIE_AW-1:0] OAMIE_ADDR_LMCNT  = 4'hc;

	localparam int OAMIE_CFG_W = 9;
	localparam int OAMIE_CFG_ENA = 0;
	localparam int OAMIE_CFG_MPLS = 1;
	localparam int OAMIE_CFG_UP = 2;
	localparam int OAMIE_CFG_OUTER = 3;
	localparam int OAMIE_CFG_LVL_LO = 4;
	localparam int OAMIE_CFG_LVL_HI = 6;
	localparam int OAMIE_CFG_INDEP = 7;
	localparam int OAMIE_CFG_SYNTHETIC_LOSS_MEAS = 8;
	localparam logic [OAMIE_CFG_W-1:0] OAMIE_CFG_RST = 9'h000;

	localparam int OAMIE_EXTR_W = 9;
	localparam int OAMIE_EXTR_Q_LO = 0;
	localparam int OAMIE_EXTR_Q_HI = 2;
	localparam int OAMIE_EXTR_ERR_EN = 3;
	localparam int OAMIE_EXTR_ERR_ONCE = 4;
	localparam int OAMIE_EXTR_TYPE_LO = 5;
	localparam int OAMIE_EXTR_TYPE_HI = 7;
	localparam int OAMIE_EXTR_TYPE_ONCE = 8;
	localparam logic [OAMIE_EXTR_W-1:0] OAMIE_EXTR_RST = 9'h000;

	localparam int OAMIE_ST_W = 2;
	localparam int OAMIE_ST_ERR = 0;
	localparam int OAMIE_ST_TYPE = 1;

	localparam int OAMIE_NMSG = 4;
	localparam logic [OAMIE_OPW-1:0] OAMIE_MSG_OP [OAMIE_NMSG] = '{8'h2b, 8'h2f, 8'h03, 8'h37};
	localparam logic [OAMIE_OPW-1:0] OAMIE_RSP_OP [OAMIE_NMSG] = '{8'h2a, 8'h2e, 8'h02, 8'h36};
	localparam int OAMIE_SLM_IDX = 3;
	localparam logic [OAMIE_OPW-1:0] OAMIE_OP_1SL = 8'h35;

	typedef enum logic [1:0] {
		ACT_NONE              = 2'b00,
		plain_inject_cmd      = 2'b01,
		masquerade_inject_cmd = 2'b10
	} oamie_act_e;

	typedef enum logic [1:0] {
		inner_rewriter_point = 2'b00,
		outer_rewriter_point = 2'b01,
		outer_analyzer_point = 2'b10,
		inner_analyzer_point = 2'b11
	} oamie_point_e;

	typedef enum logic [1:0] {
		TYPE_NONE              = 2'b00,
		type_y1731_pdu         = 2'b01,
		type_mplstp_pdu        = 2'b10,
		type_sequence_numbered = 2'b11
	} oamie_pdu_e;

	typedef enum logic [1:0] {
		VERDICT_DATA    = 2'b00,
		VERDICT_DISCARD = 2'b01,
		VERDICT_PROCESS = 2'b10
	} oamie_verdict_e;

	localparam logic EXTR_INGRESS = 1'b0;
	localparam logic EXTR_EGRESS  = 1'b1;

	typedef struct packed {
		logic [OAMIE_CFG_W-1:0]  cfg;
		logic [OAMIE_EXTR_W-1:0] extr;
		logic [OAMIE_ST_W-1:0]   done;
		logic [OAMIE_DW-1:0]     lm;
		logic [OAMIE_DW-1:0]     rdata;
		logic                    ov;
		logic [1:0]              verdict;
		logic                    ext;
		logic                    ept;
		logic [OAMIE_QW-1:0]     q;
		logic [OAMIE_OPW-1:0]    op;
		logic [OAMIE_OPW-1:0]    eop;
		logic                    swap;
		logic                    emod;
		logic                    eresp;
		logic                    lmc;
	} oamie_state_s;

endpackage

// >>> hw/oamie_opmap.sv
// Message to response opcode map for looped PDUs
`timescale 1ns/10ps
`default_nettype none
module oamie_opmap
	import oamie_pkg::*;
(
	input  wire logic [OAMIE_OPW-1:0] op,
	output logic                      is_msg,
	output logic [OAMIE_OPW-1:0]      rsp_op,
	output logic                      is_synthetic_loss_meas
);

	logic [OAMIE_NMSG-1:0] hit;
	logic [OAMIE_OPW-1:0]  part [OAMIE_NMSG];

	genvar i;
	generate
		for (i = 0; i < OAMIE_NMSG; i++) begin : g_ent
			assign hit[i] = (op == OAMIE_MSG_OP[i]);
			assign part[i] = hit[i] ? OAMIE_RSP_OP[i] : '0;
		end
	endgenerate

	always_comb begin
		rsp_op = op;
		for (int k = 0; k < OAMIE_NMSG; k++) begin
			if (hit[k]) begin
				rsp_op = part[k];
			end
		end
	end

	assign is_msg = |hit;
	assign is_synthetic_loss_meas = hit[OAMIE_SLM_IDX] || (op == OAMIE_RSP_OP[OAMIE_SLM_IDX])
		|| (op == OAMIE_OP_1SL);

endmodule
`default_nettype wire

// >>> dv/oamie_top_chk.sv
// Assertions on the OAM endpoint decision outputs
`timescale 1ns/10ps
`default_nettype none
module oamie_chk
	import oamie_pkg::*;
(
	input wire logic		CLK,
	input wire logic		RST,
	input wire logic [OAMIE_AW-1:0]	ADDR,
	input wire logic [OAMIE_DW-1:0]	WR_DATA,
	input wire logic		WR,
	input wire logic		IN_VALID,
	input wire logic		IN_RX,
	input wire logic [7:0]		IN_OPCODE,
	input wire logic		IN_LOOPED,
	input wire logic		IN_ERROR,
	input wire logic		OUT_VALID,
	input wire logic [1:0]		OUT_VERDICT,
	input wire logic [7:0]		OUT_OPCODE,
	input wire logic		OUT_MAC_SWAP,
	input wire logic		OUT_EXTRACT,
	input wire logic		OUT_EXTR_POINT,
	input wire logic [7:0]		OUT_EXTR_OPCODE,
	input wire logic		OUT_EXTR_MODIFIED,
	input wire logic		OUT_EXTR_RESPONSE,
	input wire logic		OUT_LM_COUNT
);
	logic	up;
	logic	mpls;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	// Endpoint kind as last written
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			up <= 1'b0;
			mpls <= 1'b0;
		end else if (WR && ADDR == OAMIE_ADDR_CFG) begin
			up <= WR_DATA[OAMIE_CFG_UP];
			mpls <= WR_DATA[OAMIE_CFG_MPLS];
		end
	end
	valid_pace_a: assert property (OUT_VALID == $past(IN_VALID))
		else $error("decision out of step");
	extr_proc_a: assert property (
		OUT_EXTRACT |-> OUT_VALID && OUT_VERDICT == VERDICT_PROCESS)
		else $error("extract of unprocessed frame");
	tx_unmod_a: assert property (
		OUT_EXTRACT |-> OUT_EXTR_MODIFIED == $past(IN_RX) && ($past(IN_RX) || $past(IN_ERROR)))
		else $error("tx extract wrong");
	down_point_a: assert property (
		OUT_VALID && !$past(up) |-> OUT_EXTR_POINT == EXTR_INGRESS)
		else $error("down extract not at ingress");
	up_point_a: assert property (
		OUT_VALID && $past(up) |-> OUT_EXTR_POINT == !$past(IN_LOOPED))
		else $error("up extract point wrong");
	swap_loop_a: assert property (
		OUT_VALID && OUT_MAC_SWAP |-> $past(IN_LOOPED) && OUT_VERDICT == VERDICT_PROCESS)
		else $error("swap without loop");
	resp_op_a: assert property (
		OUT_VALID && OUT_MAC_SWAP |-> OUT_OPCODE == $past(IN_OPCODE) - 8'h01)
		else $error("response opcode wrong");
	down_op_a: assert property (
		OUT_EXTRACT && !$past(up) |-> OUT_EXTR_OPCODE == $past(IN_OPCODE))
		else $error("down extract opcode changed");
	resp_copy_a: assert property (
		OUT_VALID && OUT_EXTR_RESPONSE |-> $past(up) && $past(IN_LOOPED))
		else $error("response copy wrong");
	lm_eth_a: assert property (
		OUT_VALID && OUT_LM_COUNT |-> !$past(mpls) && OUT_VERDICT != VERDICT_DISCARD)
		else $error("loss count wrong");
endmodule
bind oamie_top oamie_chk u_chk (.CLK, .RST, .ADDR, .WR_DATA, .WR, .IN_VALID, .IN_RX,
	.IN_OPCODE, .IN_LOOPED, .IN_ERROR, .OUT_VALID, .OUT_VERDICT, .OUT_OPCODE,
	.OUT_MAC_SWAP, .OUT_EXTRACT, .OUT_EXTR_POINT, .OUT_EXTR_OPCODE,
	.OUT_EXTR_MODIFIED, .OUT_EXTR_RESPONSE, .OUT_LM_COUNT);
`default_nettype wire

// >>> dv/oamie_inj.sv
// Injection source model setting the pipeline header fields
`timescale 1ns/10ps
`default_nettype none
module oamie_inj
	import oamie_pkg::*;
#(
	parameter logic [3:0]	NET_PORT = 4'h1
)
(
	input wire logic	inj,
	input wire logic	up,
	input wire logic	outer,
	input wire logic	bad,
	output logic [1:0]	act,
	output logic [1:0]	point,
	output logic [3:0]	dport
);
	always_comb begin
		act = up ? masquerade_inject_cmd : plain_inject_cmd;
		point = up ? (outer ? outer_analyzer_point : inner_analyzer_point)
			: (outer ? outer_rewriter_point : inner_rewriter_point);
		dport = up ? 4'h0 : NET_PORT;
		if (!inj)
			act = ACT_NONE;
		if (bad)
			point = up ? inner_rewriter_point : outer_analyzer_point;
	end
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Testbench for the OAM endpoint decision block
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import oamie_pkg::*;
;
	localparam logic [1:0]	pr = VERDICT_PROCESS;
	localparam logic [1:0]	dt = VERDICT_DATA;
	localparam logic [7:0]	msg = 8'h2b;
	logic		CLK, RST, WR, RD, IN_VALID, IN_RX, IN_LOOPED, IN_ERROR;
	logic		OUT_VALID, OUT_MAC_SWAP, OUT_EXTRACT, OUT_EXTR_POINT;
	logic		OUT_EXTR_MODIFIED, OUT_EXTR_RESPONSE, OUT_LM_COUNT, inj, up, outer, bad;
	logic [3:0]	ADDR, dport;
	logic [31:0]	WR_DATA, RD_DATA;
	logic [1:0]	IN_ACT, IN_POINT, IN_PDU_TYPE, OUT_VERDICT, typ;
	logic [2:0]	IN_LEVEL, OUT_QUEUE;
	logic [7:0]	IN_OPCODE, OUT_OPCODE, OUT_EXTR_OPCODE;
	int		err_total, checked;
	oamie_inj u_inj (.inj, .up, .outer, .bad, .act(IN_ACT), .point(IN_POINT), .dport);
	oamie_top u_dut (.CLK, .RST, .ADDR, .WR_DATA, .WR, .RD, .RD_DATA, .IN_VALID, .IN_RX,
		.IN_ACT, .IN_POINT, .IN_PDU_TYPE, .IN_LEVEL, .IN_OPCODE, .IN_LOOPED, .IN_ERROR,
		.OUT_VALID, .OUT_VERDICT, .OUT_OPCODE, .OUT_MAC_SWAP, .OUT_EXTRACT, .OUT_EXTR_POINT,
		.OUT_QUEUE, .OUT_EXTR_OPCODE, .OUT_EXTR_MODIFIED, .OUT_EXTR_RESPONSE, .OUT_LM_COUNT);
	initial begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge CLK);
		ADDR <= a;
		WR_DATA <= v;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1;
		chk("rdata", e, RD_DATA);
	endtask
	// Descriptor: rx, inject, wrong point, level, opcode, looped, error
	task automatic d(input logic rx, i, b, input logic [2:0] lv, input logic [7:0] op,
		input logic lp, er, input logic [1:0] ev, input logic ex);
		@(posedge CLK);
		IN_VALID <= 1'b1;
		IN_RX <= rx;
		inj <= i;
		bad <= b;
		IN_LEVEL <= lv;
		IN_OPCODE <= op;
		IN_LOOPED <= lp;
		IN_ERROR <= er;
		IN_PDU_TYPE <= typ;
		@(posedge CLK);
		IN_VALID <= 1'b0;
		#1;
		chk("verdict", 32'(ev), 32'(OUT_VERDICT));
		chk("extract", 32'(ex), 32'(OUT_EXTRACT));
	endtask
	initial begin
		RST = 1'b1;
		{WR, RD, IN_VALID, IN_RX, IN_LOOPED, IN_ERROR, inj, up, outer, bad} = '0;
		{ADDR, WR_DATA, IN_PDU_TYPE, IN_LEVEL, IN_OPCODE} = '0;
		typ = type_y1731_pdu;
		repeat (5) @(posedge CLK);
		RST <= 1'b0;
		for (int a = 0; a < 16; a += 2)
			rd(4'(a), 32'h0);
		wr(4'h6, 32'hffffffff);
		rd(4'h6, 32'h0);
		wr(OAMIE_ADDR_CFG, 32'h031);
		rd(OAMIE_ADDR_CFG, 32'h031);
		wr(OAMIE_ADDR_EXTR, 32'h02d);
		d(0, 1, 0, 3, msg, 0, 0, pr, 0);
		chk("lm", 1, OUT_LM_COUNT);
		chk("dport", 32'h1, dport);
		d(0, 0, 0, 3, msg, 0, 0, dt, 0);
		d(0, 1, 1, 3, msg, 0, 1, dt, 0);
		d(1, 0, 0, 2, msg, 0, 0, VERDICT_DISCARD, 0);
		d(1, 0, 0, 5, msg, 0, 0, dt, 0);
		d(0, 1, 0, 3, msg, 0, 1, pr, 1);
		chk("queue", 5, OUT_QUEUE);
		chk("modified", 0, OUT_EXTR_MODIFIED);
		d(1, 0, 0, 3, msg, 1, 0, pr, 1);
		chk("swap", 1, OUT_MAC_SWAP);
		chk("opcode", 8'h2a, OUT_OPCODE);
		chk("extr op", msg, OUT_EXTR_OPCODE);
		chk("point", EXTR_INGRESS, OUT_EXTR_POINT);
		chk("modified", 1, OUT_EXTR_MODIFIED);
		d(1, 0, 0, 3, msg, 0, 0, pr, 1);
		chk("swap", 0, OUT_MAC_SWAP);
		typ = TYPE_NONE;
		d(1, 0, 0, 3, msg, 1, 0, dt, 0);
		typ = type_y1731_pdu;
		wr(OAMIE_ADDR_CFG, 32'h0b1);
		d(1, 0, 0, 3, msg, 1, 0, dt, 0);
		wr(OAMIE_ADDR_CFG, 32'h03d);
		up <= 1'b1;
		outer <= 1'b1;
		for (int k = 0; k < OAMIE_NMSG; k++) begin
			d(1, 0, 0, 3, OAMIE_MSG_OP[k], 1, 0, pr, 1);
			chk("extr op", OAMIE_RSP_OP[k], OUT_EXTR_OPCODE);
			chk("response", 1, OUT_EXTR_RESPONSE);
		end
		d(1, 0, 0, 3, 8'h03, 0, 0, pr, 1);
		chk("point", EXTR_EGRESS, OUT_EXTR_POINT);
		chk("extr op", 8'h03, OUT_EXTR_OPCODE);
		chk("response", 0, OUT_EXTR_RESPONSE);
		chk("dport", 32'h0, dport);
		d(0, 1, 0, 3, msg, 0, 0, pr, 0);
		d(0, 1, 1, 3, msg, 0, 0, dt, 0);
		wr(OAMIE_ADDR_CFG, 32'h003);
		up <= 1'b0;
		outer <= 1'b0;
		typ = type_mplstp_pdu;
		d(0, 1, 0, 5, msg, 0, 0, pr, 0);
		chk("lm", 0, OUT_LM_COUNT);
		d(0, 0, 0, 5, msg, 0, 0, dt, 0);
		wr(OAMIE_ADDR_CFG, 32'h083);
		d(0, 1, 0, 5, msg, 0, 0, dt, 0);
		typ = type_y1731_pdu;
		wr(OAMIE_ADDR_CFG, 32'h031);
		wr(OAMIE_ADDR_EXTR, 32'h01d);
		d(0, 1, 0, 3, msg, 0, 1, pr, 1);
		d(0, 1, 0, 3, msg, 0, 1, pr, 0);
		rd(OAMIE_ADDR_STATUS, 32'h1);
		wr(OAMIE_ADDR_STATUS, 32'h1);
		rd(OAMIE_ADDR_STATUS, 32'h0);
		d(0, 1, 0, 3, msg, 0, 1, pr, 1);
		wr(OAMIE_ADDR_CFG, 32'h131);
		wr(OAMIE_ADDR_LMCNT, 32'h0);
		d(0, 1, 0, 3, 8'h37, 0, 0, pr, 0);
		chk("lm", 1, OUT_LM_COUNT);
		d(0, 1, 0, 3, msg, 0, 0, pr, 0);
		chk("lm", 0, OUT_LM_COUNT);
		rd(OAMIE_ADDR_LMCNT, 32'h1);
		wr(OAMIE_ADDR_CFG, 32'h00b);
		wr(OAMIE_ADDR_EXTR, 32'h142);
		outer <= 1'b1;
		typ = type_mplstp_pdu;
		d(1, 0, 0, 0, msg, 0, 0, pr, 1);
		chk("queue", 2, OUT_QUEUE);
		chk("modified", 1, OUT_EXTR_MODIFIED);
		d(1, 0, 0, 0, msg, 0, 0, pr, 0);
		rd(OAMIE_ADDR_STATUS, 32'h3);
		d(0, 1, 0, 0, msg, 0, 0, pr, 0);
		typ = type_sequence_numbered;
		d(1, 0, 0, 0, msg, 0, 0, pr, 0);
		complete_run();
	end
	initial begin
		repeat (3000) @(posedge CLK);
		err_total++;
		complete_run();
	end
endmodule
`default_nettype wire
